// [pkg/esc_consts.vh]
// Constants for the elapsed seconds counter serial port
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH
`define ESC_CMD_BITS        8
`define ESC_DATA_BITS       32
`define ESC_CMD_SEL_CONT    7
`define ESC_CMD_SEL_PWR     6
`define ESC_CMD_TRIM_HI     5
`define ESC_CMD_TRIM_LO     3
`define ESC_CMD_CLR_CONT    2
`define ESC_CMD_CLR_PWR     1
`define ESC_CMD_READ        0
`define ESC_TRIM_RESET      3'h3
`define ESC_TRIM_STOP       3'h0
`define ESC_CLK_HZ          100000000
`define ESC_XTAL_HZ         32768
`define ESC_XTAL_DIV        ((`ESC_CLK_HZ + `ESC_XTAL_HZ - 1) / `ESC_XTAL_HZ)
`define ESC_TICKS_PER_SEC   32768
`define ESC_TRIM_STEP       64
`endif

// [logic/esc_port.v]
// Two seconds counters with a three-wire serial access port
// Notes on behaviour
// - Port is active only while select high
// - First eight bits form the command
// - After command, clocks move counter data
// - No main power disables the serial port
// - Without main power only continuous counter runs
// - Bit 7 continuous, bit 6 powered counter
// - Read copies counter at command end
// - Write loads all 32 bits at once
// - Both selects load trim, ignore further clocks
// - Higher trim faster, zero stops oscillator
// - Bit 2 clears continuous counter at deselect
// - Bit 1 clears powered counter at deselect
// - Bit 0: zero writes, one reads
// - Sample on rise, present on fall
// - Deselect aborts transfer, releases data line
// - After 32 written bits ignore clocks
// - First read bit at fall after command
// - Drive data only while serial clock low
// - Counters count seconds from crystal timebase
// - Trim only with bit 0 clear, counters untouched
// - One hertz tick while main power present
`timescale 1ns/1ps
`include "esc_consts.vh"
module esc_port
#(
  parameter XTAL_DIV = `ESC_XTAL_DIV,
  parameter TICKS    = `ESC_TICKS_PER_SEC
)
(
  input  wire        clk_in,
  input  wire        rst_in,
  input  wire        main_power_in,
  input  wire        sel_in,
  input  wire        sclk_in,
  input  wire        dq_in,
  output reg         dq_out,
  output reg         dq_oe_out,
  output reg         second_tick_out,
  output reg  [31:0] cont_count_out,
  output reg  [31:0] pwr_count_out
);

  localparam ST_CMD  = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_IDLE = 2'd2;
  // Last bit indices of the command and data phases
  localparam [31:0] CMD_SPAN  = `ESC_CMD_BITS - 1;
  localparam [31:0] DATA_SPAN = `ESC_DATA_BITS - 1;
  localparam [2:0]  CMD_LAST  = CMD_SPAN[2:0];
  localparam [5:0]  DATA_LAST = DATA_SPAN[5:0];

  // Two-flop synchronisers for the pins
  reg  [1:0] sel_sync;
  reg  [1:0] sclk_sync;
  reg  [1:0] dq_sync;
  reg  [1:0] pwr_sync;
  reg        sclk_prev;
  reg        sel_prev;
  wire       sel_s   = sel_sync[1];
  wire       sclk_s  = sclk_sync[1];
  // Pin edges are seen three clocks late, so half periods need four
  wire       port_on = sel_s & pwr_sync[1];
  wire       rise    = port_on & sclk_s & ~sclk_prev;
  wire       fall    = port_on & ~sclk_s & sclk_prev;
  wire       desel   = sel_prev & ~sel_s;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      sel_sync  <= 2'h0;
      sclk_sync <= 2'h0;
      dq_sync   <= 2'h0;
      pwr_sync  <= 2'h0;
      sclk_prev <= 1'b0;
      sel_prev  <= 1'b0;
    end
    else
    begin
      sel_sync  <= {sel_sync[0], sel_in};
      sclk_sync <= {sclk_sync[0], sclk_in};
      dq_sync   <= {dq_sync[0], dq_in};
      pwr_sync  <= {pwr_sync[0], main_power_in};
      sclk_prev <= sclk_s;
      sel_prev  <= sel_s;
    end
  end

  // Two-entry buffer between port and counters for write words
  reg  [31:0] buf_data [0:1];
  reg         wr_ptr;
  reg         rd_ptr;
  reg  [1:0]  buf_cnt;
  reg         buf_tgt [0:1];
  wire        buf_in_ready  = (buf_cnt != 2'd2);
  wire        buf_out_valid = (buf_cnt != 2'd0);
  reg         buf_in_valid;
  reg  [31:0] buf_in_data;
  reg         buf_in_tgt;
  // One word per write transfer, so two entries ride out any clear stall

  // Serial engine
  reg  [1:0]  state;
  reg  [2:0]  bit_cnt;
  reg  [5:0]  data_cnt;
  reg  [7:0]  cmd;
  reg  [31:0] shift;
  reg  [2:0]  trim;
  reg         clr_cont_pend;
  reg         clr_pwr_pend;
  // A clear needs the supply; a dead port drops it
  wire        clr_now = desel & pwr_sync[1] & (clr_cont_pend | clr_pwr_pend);
  wire [7:0]  next_cmd = {dq_sync[1], cmd[7:1]};
  wire        sel_cont = next_cmd[`ESC_CMD_SEL_CONT];
  wire        sel_pwr  = next_cmd[`ESC_CMD_SEL_PWR];
  // Counters take a load unless this cycle is a clear, which must win
  wire        buf_out_ready = ~clr_now;
  wire        push          = buf_in_valid & buf_in_ready;
  wire        pop           = buf_out_valid & buf_out_ready;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state         <= ST_CMD;
      bit_cnt       <= 3'h0;
      data_cnt      <= 6'h0;
      cmd           <= 8'h0;
      shift         <= 32'h0;
      trim          <= `ESC_TRIM_RESET;
      clr_cont_pend <= 1'b0;
      clr_pwr_pend  <= 1'b0;
      buf_in_valid  <= 1'b0;
      buf_in_data   <= 32'h0;
      buf_in_tgt    <= 1'b0;
      dq_out        <= 1'b0;
      dq_oe_out     <= 1'b0;
    end
    else
    begin
      if (push)
        buf_in_valid <= 1'b0;
      if (!port_on)
      begin
        state     <= ST_CMD;
        bit_cnt   <= 3'h0;
        data_cnt  <= 6'h0;
        dq_oe_out <= 1'b0;
        if (desel | ~pwr_sync[1])
        begin
          clr_cont_pend <= 1'b0;
          clr_pwr_pend  <= 1'b0;
        end
      end
      else
      begin
        case (state)
          ST_CMD:
          begin
            if (rise)
            begin
              cmd     <= next_cmd;
              bit_cnt <= bit_cnt + 3'd1;
              // Eighth rise decides what the rest of the transfer does
              if (bit_cnt == CMD_LAST)
              begin
                data_cnt <= 6'h0;
                if (sel_cont & sel_pwr)
                begin
                  if (!next_cmd[`ESC_CMD_READ])
                    trim <= next_cmd[`ESC_CMD_TRIM_HI:`ESC_CMD_TRIM_LO];
                  state <= ST_IDLE;
                end
                else if (sel_cont | sel_pwr)
                begin
                  shift <= sel_cont ? cont_count_out : pwr_count_out;
                  state <= ST_DATA;
                end
                else
                begin
                  clr_cont_pend <= next_cmd[`ESC_CMD_CLR_CONT];
                  clr_pwr_pend  <= next_cmd[`ESC_CMD_CLR_PWR];
                  state         <= ST_IDLE;
                end
              end
            end
          end
          ST_DATA:
          begin
            if (cmd[`ESC_CMD_READ])
            begin
              // Copy taken at command end, so a tick cannot tear the word
              if (fall)
              begin
                dq_out    <= shift[0];
                dq_oe_out <= 1'b1;
              end
              else if (rise)
              begin
                dq_oe_out <= 1'b0;
                shift     <= {1'b0, shift[31:1]};
                data_cnt  <= data_cnt + 6'd1;
                if (data_cnt == DATA_LAST)
                  state <= ST_IDLE;
              end
            end
            else if (rise)
            begin
              // Whole word reaches the counter as one buffered load
              shift    <= {dq_sync[1], shift[31:1]};
              data_cnt <= data_cnt + 6'd1;
              if (data_cnt == DATA_LAST)
              begin
                buf_in_valid <= 1'b1;
                buf_in_data  <= {dq_sync[1], shift[31:1]};
                buf_in_tgt   <= cmd[`ESC_CMD_SEL_CONT];
                state        <= ST_IDLE;
              end
            end
          end
          default:
          begin
            // Trailing clocks are ignored until deselect
            dq_oe_out <= 1'b0;
          end
        endcase
      end
    end
  end

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_ptr  <= 1'b0;
      rd_ptr  <= 1'b0;
      buf_cnt <= 2'd0;
    end
    else
    begin
      if (push)
      begin
        buf_data[wr_ptr] <= buf_in_data;
        buf_tgt[wr_ptr]  <= buf_in_tgt;
        wr_ptr           <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
      buf_cnt <= buf_cnt + {1'b0, push} - {1'b0, pop};
    end
  end

  // Trimmed timebase: trim shifts the divided period around the nominal
  reg  [15:0] xtal_div;
  reg         xtal_en;
  reg  [16:0] sub_sec;
  // Nominal trim adds nothing; each step moves the second by one trim step
  localparam [31:0] LEN_BASE = TICKS + `ESC_TRIM_STEP * `ESC_TRIM_RESET;
  wire [31:0] trim_cut  = `ESC_TRIM_STEP * {29'h0, trim};
  wire [31:0] len_full  = LEN_BASE - trim_cut;
  // Sub-second counter is 17 bits; sane tick counts never need more
  wire [16:0] sec_len   = len_full[16:0];
  wire [16:0] sec_len_t = (trim == `ESC_TRIM_STOP) ? 17'h0 : sec_len[16:0];
  wire [16:0] half_len  = {1'b0, sec_len_t[16:1]};
  reg         sec_en;

  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      xtal_div <= 16'h0;
      xtal_en  <= 1'b0;
      sub_sec  <= 17'h0;
      sec_en   <= 1'b0;
    end
    else
    begin
      // Both enables are one-cycle pulses
      xtal_en <= 1'b0;
      sec_en  <= 1'b0;
      // Zero trim freezes the divider, not only the second count
      if (trim != `ESC_TRIM_STOP)
      begin
        if (xtal_div == XTAL_DIV - 1)
        begin
          xtal_div <= 16'h0;
          xtal_en  <= 1'b1;
        end
        else
          xtal_div <= xtal_div + 16'd1;
      end
      if (xtal_en)
      begin
        if (sub_sec + 17'd1 >= sec_len_t)
        begin
          sub_sec <= 17'h0;
          sec_en  <= 1'b1;
        end
        else
          sub_sec <= sub_sec + 17'd1;
      end
    end
  end

  // Counters and the tick output
  always @(posedge clk_in)
  begin
    if (rst_in)
    begin
      cont_count_out  <= 32'h0;
      pwr_count_out   <= 32'h0;
      second_tick_out <= 1'b0;
    end
    else
    begin
      // Square wave, high for the first half of each second
      second_tick_out <= pwr_sync[1] & (trim != `ESC_TRIM_STOP) & (sub_sec < half_len);
      // Clear beats a buffered load and an increment in one cycle
      if (clr_now & clr_cont_pend)
        cont_count_out <= 32'h0;
      else if (pop & buf_tgt[rd_ptr])
        cont_count_out <= buf_data[rd_ptr];
      else if (sec_en)
        cont_count_out <= cont_count_out + 32'd1;
      // Without supply the powered counter simply holds its value
      if (clr_now & clr_pwr_pend)
        pwr_count_out <= 32'h0;
      else if (pop & ~buf_tgt[rd_ptr])
        pwr_count_out <= buf_data[rd_ptr];
      else if (sec_en & pwr_sync[1])
        pwr_count_out <= pwr_count_out + 32'd1;
    end
  end

endmodule

// [bench/esc_checker.sv]
// Pin-level assertions for the seconds counter serial port
`timescale 1ns/1ps
module esc_checker
(
  input wire        clk_in,
  input wire        rst_in,
  input wire        main_power_in,
  input wire        sel_in,
  input wire        sclk_in,
  input wire        dq_out,
  input wire        dq_oe_out,
  input wire        second_tick_out,
  input wire [31:0] cont_count_out,
  input wire [31:0] pwr_count_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Margin covers two sync flops and edge detect
  sequence sel_idle;
    !sel_in [*6];
  endsequence
  sequence power_gone;
    !main_power_in [*6];
  endsequence
  // Clears land within four cycles of deselect
  sequence port_quiet;
    !sel_in [*8];
  endsequence
  chk_oe_deselect: assert property (sel_idle |-> !dq_oe_out)
    else $error("data line driven while deselected");
  chk_oe_clk_high: assert property (sclk_in [*6] |-> !dq_oe_out)
    else $error("data line driven while serial clock high");
  chk_oe_no_power: assert property (power_gone |-> !dq_oe_out)
    else $error("data line driven without main power");
  chk_pwr_hold: assert property (power_gone |-> $stable(pwr_count_out))
    else $error("powered counter moved without main power");
  chk_tick_no_power: assert property (power_gone |-> !second_tick_out)
    else $error("tick output active without main power");
  chk_cont_step: assert property (port_quiet |-> cont_count_out - $past(cont_count_out) <= 32'h1)
    else $error("continuous counter jumped while idle");
  chk_pwr_step: assert property (port_quiet |-> pwr_count_out - $past(pwr_count_out) <= 32'h1)
    else $error("powered counter jumped while idle");
  chk_dq_stands: assert property (dq_oe_out && $past(dq_oe_out) |-> $stable(dq_out))
    else $error("read bit changed while driven");
endmodule

// [bench/esc_host.sv]
// Host model driving the three-wire serial port
`timescale 1ns/1ps
module esc_host
(
  input  wire  clk_in,
  input  wire  dq_in,
  output logic sel_out = 1'b0,
  output logic sclk_out = 1'b0,
  output logic dq_out = 1'b0
);
  task automatic half();
    repeat (8) @(posedge clk_in);
    #1;
  endtask
  // Released line toggles so a stale value never reads as valid
  task automatic xfer(input logic [7:0] cmd, input logic [39:0] d, input int n, output logic [31:0] rd);
    logic [47:0] b;
    b = {d, cmd};
    sel_out = 1'b1;
    for (int i = 0; i < 8 + n; i++)
    begin
      half();
      sclk_out = 1'b0;
      dq_out = (i > 7 && cmd[0]) ? ~dq_out : b[i];
      half();
      if (i > 7 && i < 40)
        rd[i - 8] = dq_in;
      sclk_out = 1'b1;
    end
    half();
    sel_out = 1'b0;
    half();
    sclk_out = 1'b0;
  endtask
endmodule

// [bench/esc_port_bench.sv]
// Self-checking bench for the seconds counter serial port
`timescale 1ns/1ps
module esc_port_bench;
  logic         clk_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         main_power_in = 1'b1;
  wire          sel;
  wire          sclk;
  wire          host_dq;
  wire          dq_out;
  wire          dq_oe_out;
  wire  [31:0]  cont;
  wire  [31:0]  pwr;
  wire          tick;
  wire          dq_wire = dq_oe_out ? dq_out : host_dq;
  int           err_count = 0;
  int           total_checks = 0;
  logic [31:0]  rd;
  logic [31:0]  c0;
  logic [31:0]  p0;
  logic [31:0]  rises;
  logic         t0;
  // Command, data, continuous and powered counts afterwards
  logic [103:0] rows [11] = '{
    {8'h80, 32'h12345678, 32'h12345678, 32'h0},
    {8'h40, 32'ha5a50f0f, 32'h12345678, 32'ha5a50f0f},
    {8'h81, 32'h0, 32'h12345678, 32'ha5a50f0f},
    {8'h41, 32'h0, 32'h12345678, 32'ha5a50f0f},
    {8'hf9, 32'h0, 32'h12345678, 32'ha5a50f0f},
    {8'h38, 32'hffffffff, 32'h12345678, 32'ha5a50f0f},
    {8'h04, 32'h0, 32'h0, 32'ha5a50f0f},
    {8'h80, 32'hffffffff, 32'hffffffff, 32'ha5a50f0f},
    {8'h02, 32'h0, 32'hffffffff, 32'h0},
    {8'h40, 32'h1, 32'hffffffff, 32'h1},
    {8'h06, 32'h0, 32'h0, 32'h0}};
  always #5 clk_in = ~clk_in;
  esc_port #(.XTAL_DIV(1), .TICKS(256)) uut
  (
    .clk_in(clk_in), .rst_in(rst_in), .main_power_in(main_power_in),
    .sel_in(sel), .sclk_in(sclk), .dq_in(dq_wire), .dq_out(dq_out),
    .dq_oe_out(dq_oe_out), .second_tick_out(tick), .cont_count_out(cont), .pwr_count_out(pwr)
  );
  esc_host host (.clk_in(clk_in), .dq_in(dq_wire), .sel_out(sel), .sclk_out(sclk), .dq_out(host_dq));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic run(input logic [7:0] cmd, input logic [39:0] d, input int n);
    host.xfer(cmd, d, n, rd);
    repeat (600) @(posedge clk_in);
    #1;
  endtask
  task automatic rate(input logic [7:0] cmd, input logic [31:0] lo, input logic [31:0] hi);
    run(cmd, 40'h0, 0);
    c0 = cont;
    repeat (1280) @(posedge clk_in);
    #1;
    chk("seconds in window", 32'h1, {31'h0, cont - c0 >= lo && cont - c0 <= hi});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_in);
    err_count++;
    $display("MISMATCH watchdog expected done seen hang");
    test_done();
  end
  initial
  begin
    repeat (12) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk("cont reset", 32'h0, cont);
    run(8'hc0, 40'h0, 0);
    run(8'h06, 40'h0, 0);
    chk("cont clear", 32'h0, cont);
    chk("pwr clear", 32'h0, pwr);
    $display("stop and clear test done");
    foreach (rows[i])
    begin
      run(rows[i][103:96], {8'h0, rows[i][95:64]}, 32);
      if (rows[i][96] && rows[i][103] != rows[i][102])
        chk("read data", rows[i][103] ? rows[i][63:32] : rows[i][31:0], rd);
      chk("cont", rows[i][63:32], cont);
      chk("pwr", rows[i][31:0], pwr);
      $display("row %0d done", i);
    end
    run(8'h80, 40'hff_cafe_f00d, 40);
    chk("extra clocks", 32'hcafef00d, cont);
    run(8'h40, 40'h0_dead_beef, 16);
    chk("aborted write", 32'h0, pwr);
    $display("extra clock and abort test done");
    run(8'hd8, 40'h0, 0);
    rises = 32'h0;
    repeat (512)
    begin
      t0 = tick;
      @(posedge clk_in);
      #1;
      rises = rises + {31'h0, tick & ~t0};
    end
    chk("tick rises", 32'h2, rises);
    main_power_in = 1'b0;
    repeat (10) @(posedge clk_in);
    #1;
    chk("tick off", 32'h0, {31'h0, tick});
    c0 = cont;
    p0 = pwr;
    host.xfer(8'h80, 40'h0, 32, rd);
    repeat (1904) @(posedge clk_in);
    #1;
    chk("pwr held", p0, pwr);
    chk("cont running", 32'h1, {31'h0, cont - c0 >= 32'h9 && cont - c0 <= 32'hb});
    main_power_in = 1'b1;
    $display("power loss test done");
    rate(8'he8, 32'h9, 32'hb);
    rate(8'hc8, 32'h3, 32'h4);
    $display("trim rate test done");
    rst_in = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    chk("cont reset", 32'h0, cont);
    chk("pwr reset", 32'h0, pwr);
    repeat (300) @(posedge clk_in);
    #1;
    chk("cont restart", 32'h1, cont);
    chk("pwr restart", 32'h1, pwr);
    $display("mid-run reset test done");
    test_done();
  end
endmodule
bind esc_port esc_checker chk_i
(
  .clk_in(clk_in), .rst_in(rst_in), .main_power_in(main_power_in), .sel_in(sel_in),
  .sclk_in(sclk_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .second_tick_out(second_tick_out),
  .cont_count_out(cont_count_out), .pwr_count_out(pwr_count_out)
);
